//--- design/gpt_pkg.sv
// Notes on behaviour
// - Port A has four pins, each with an output latch and its own direction bit.
// - A port A input pin gets a pull-up when its pull-up bit is set.
// - Port A pins also feed analog, timer and interrupt alternate functions.
// - Any reset puts every port A pin in input mode.
// - With the internal oscillator, both oscillator pins work as port or analog pins.
// - With a crystal or resonator, both oscillator pins serve the oscillator only.
// - With external clock, pin B is the clock input; pin A stays usable.
// - Clock source comes from the nonvolatile option byte, never from a register.
// - Both oscillator-shared pins are pulled low while reset is held.
// - Port B pin has latch, direction, optional pull-up and interrupt input role.
// - Any reset puts the port B pin in input mode.
// - Reset-shared pin is input-only and acts as reset until the option byte says port.
// - As a port input, the reset-shared pin no longer causes reset.
// - Option byte is read after reset release; low pin before that keeps reset held.
// - Fourteen pins in all: thirteen bidirectional, one input-only, thirteen pull-ups; this block has six: five bidirectional, one input-only, five pull-ups.
// - Direction bit 0 turns the output buffer on, 1 turns it off.
// - Port read gives pin level in input mode and latch value in output mode.
// - Analog select bit 1 puts a port A pin in analog mode, port function off.
package gpt_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_PA_LATCH = 8'h00;
  localparam logic [7:0] OFF_PB_LATCH = 8'h04;
  localparam logic [7:0] OFF_PA_DIR = 8'h08;
  localparam logic [7:0] OFF_PB_DIR = 8'h0C;
  localparam logic [7:0] OFF_PA_PULLUP = 8'h10;
  localparam logic [7:0] OFF_PB_PULLUP = 8'h14;
  localparam logic [7:0] OFF_PA_ANALOG = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int PB_BIDIR_BIT = 2;
  localparam int PB_RSTPIN_BIT = 4;
  localparam int OSC_A_IDX = 2;
  localparam int OSC_B_IDX = 3;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_RSTPORT_BIT = 4;
  localparam int ST_LOADED_BIT = 5;

  // ==========================================================
  // Reset values
  localparam logic [3:0] PA_DIR_RST = 4'hF;
  localparam logic PB_DIR_RST = 1'b1;
  localparam logic [3:0] PA_LATCH_RST = 4'h0;
  localparam logic PB_LATCH_RST = 1'b0;
  localparam logic [3:0] PA_PULLUP_RST = 4'h0;
  localparam logic PB_PULLUP_RST = 1'b0;
  localparam logic [3:0] PA_ANALOG_RST = 4'h0;

  // ==========================================================
  // Option byte clock source encoding
  localparam logic [1:0] OPT_CLK_INTERNAL = 2'h0;
  localparam logic [1:0] OPT_CLK_CRYSTAL = 2'h1;
  localparam logic [1:0] OPT_CLK_EXTERNAL = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    GPT_CLK_INTERNAL = 3'b001,
    GPT_CLK_CRYSTAL = 3'b010,
    GPT_CLK_EXTERNAL = 3'b100
  } gpt_clk_e;

  typedef enum logic [1:0] {
    GPT_ST_LOAD = 2'b01,
    GPT_ST_RUN = 2'b10
  } gpt_boot_e;

endpackage

//--- design/gpt_pin_cell.sv
`timescale 1ns/1ps
module gpt_pin_cell
  import gpt_pkg::*;
(
  // Control bits
  input wire logic dir,
  input wire logic latch,
  input wire logic pu_sel,
  input wire logic analog,
  input wire logic blocked,
  input wire logic alt_out,
  // Pin side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pu_en,
  // Internal side
  output logic read_bit,
  output logic func_in,
  output logic adc_en
);

  logic usable;

  // Port function lives only when not analog and not taken by the oscillator
  assign usable = ~blocked & ~analog;
  assign pin_oe = usable & ~dir;
  assign pin_out = latch | alt_out;
  assign pu_en = usable & dir & pu_sel;
  assign read_bit = usable & (dir ? pin_in : latch);
  assign func_in = usable & pin_in;
  assign adc_en = analog & ~blocked;

endmodule

//--- design/gpt_boot_ctl.sv
`timescale 1ns/1ps
module gpt_boot_ctl
  import gpt_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Option byte straps
  input wire logic [1:0] opt_clk_sel,
  input wire logic opt_rst_is_port,
  // Reset-shared pin
  input wire logic rst_pin_in,
  // Captured configuration
  output gpt_pkg::gpt_clk_e clk_mode,
  output logic rst_is_port,
  output logic opt_loaded,
  output logic hold_reset
);

  gpt_boot_e state_q;
  gpt_clk_e clk_mode_q;
  logic rst_is_port_q;

  // Straps are taken only at the first enabled edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= GPT_ST_LOAD;
      clk_mode_q <= GPT_CLK_INTERNAL;
      rst_is_port_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        GPT_ST_LOAD: begin
          state_q <= GPT_ST_RUN;
          rst_is_port_q <= opt_rst_is_port;
          if (opt_clk_sel == OPT_CLK_CRYSTAL) begin
            clk_mode_q <= GPT_CLK_CRYSTAL;
          end else if (opt_clk_sel == OPT_CLK_EXTERNAL) begin
            clk_mode_q <= GPT_CLK_EXTERNAL;
          end else begin
            clk_mode_q <= GPT_CLK_INTERNAL;
          end
        end
        GPT_ST_RUN: begin
          state_q <= GPT_ST_RUN;
        end
        default: begin
          state_q <= GPT_ST_LOAD;
        end
      endcase
    end
  end

  // Reset request while the pin still counts as reset input
  assign opt_loaded = (state_q == GPT_ST_RUN);
  assign hold_reset = ~rst_pin_in & ~(opt_loaded & rst_is_port_q);
  assign clk_mode = clk_mode_q;
  assign rst_is_port = rst_is_port_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  boot_hold_low_a: assert property (!opt_loaded && !rst_pin_in |-> hold_reset)
    else $error("low reset pin before option load did not hold reset");
  port_ignore_a: assert property (opt_loaded && rst_is_port |-> !hold_reset)
    else $error("reset pin in port role still requests reset");
  reset_role_a: assert property (opt_loaded && !rst_is_port |-> hold_reset == !rst_pin_in)
    else $error("reset pin in reset role does not follow pin");
  opt_load_once_a: assert property ($rose(opt_loaded) |=> $stable(clk_mode) [*4])
    else $error("clock source changed after option load");

endmodule

//--- design/gpt_ports.sv
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module gpt_ports
  import gpt_pkg::*;
#(
  parameter int PA_W = 4
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Option byte straps
  input wire logic [1:0] opt_clk_sel,
  input wire logic opt_rst_is_port,
  // Port A pins (bits 2 and 3 shared with oscillator)
  input wire logic [PA_W-1:0] port_a_in,
  output logic [PA_W-1:0] port_a_out,
  output logic [PA_W-1:0] port_a_oe,
  output logic [PA_W-1:0] port_a_pullup_en,
  output logic [1:0] osc_pulldown,
  // Port B pins
  input wire logic port3_bidir_pin_in,
  output logic port3_bidir_pin_out,
  output logic port3_bidir_pin_oe,
  output logic port3_bidir_pin_pullup_en,
  input wire logic reset_shared_input_pin,
  // Alternate functions
  output logic [PA_W-1:0] adc_in_en,
  output logic [PA_W-1:0] timer_in,
  input wire logic [1:0] timer_out,
  output logic ext_irq_input_zero,
  output logic ext_irq_input_one,
  // System
  output gpt_pkg::gpt_clk_e clk_mode,
  output logic hold_reset
);
  import gpt_pkg::*;

  // ==========================================================
  // Registers
  logic [PA_W-1:0] port_a_latch_reg_q;
  logic [PA_W-1:0] port_a_direction_reg_q;
  logic [PA_W-1:0] port_a_pullup_reg_q;
  logic [PA_W-1:0] port_a_analog_select_reg_q;
  logic port_b_latch_reg_q;
  logic port_b_direction_reg_q;
  logic port_b_pullup_reg_q;

  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;
  logic rd_hit, wr_hit, wr_fire, ar_fire, wr_lane0;

  logic rst_is_port, opt_loaded;
  logic [PA_W-1:0] pa_blocked, pa_read, pa_alt_out, pa_func;
  logic pb_read, pb_func;

  // ==========================================================
  // Configuration capture from the option byte
  gpt_boot_ctl u_boot (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .opt_clk_sel(opt_clk_sel),
    .opt_rst_is_port(opt_rst_is_port),
    .rst_pin_in(reset_shared_input_pin),
    .clk_mode(clk_mode),
    .rst_is_port(rst_is_port),
    .opt_loaded(opt_loaded),
    .hold_reset(hold_reset)
  );

  // Oscillator ownership of the shared pins
  always_comb begin
    pa_blocked = '0;
    if (clk_mode == GPT_CLK_CRYSTAL) begin
      pa_blocked[OSC_A_IDX] = 1'b1;
      pa_blocked[OSC_B_IDX] = 1'b1;
    end else if (clk_mode == GPT_CLK_EXTERNAL) begin
      pa_blocked[OSC_B_IDX] = 1'b1;
    end
  end

  // Timer outputs drive pins 0 and 1, the rest carry none
  always_comb begin
    pa_alt_out = '0;
    pa_alt_out[1:0] = timer_out;
  end

  // Shared pins are pulled low while reset is held
  assign osc_pulldown = {2{~aresetn}};

  // ==========================================================
  // Pin cells
  genvar gi;
  generate
    for (gi = 0; gi < PA_W; gi++) begin : g_pa
      gpt_pin_cell u_cell (
        .dir(port_a_direction_reg_q[gi]),
        .latch(port_a_latch_reg_q[gi]),
        .pu_sel(port_a_pullup_reg_q[gi]),
        .analog(port_a_analog_select_reg_q[gi]),
        .blocked(pa_blocked[gi]),
        .alt_out(pa_alt_out[gi]),
        .pin_in(port_a_in[gi]),
        .pin_out(port_a_out[gi]),
        .pin_oe(port_a_oe[gi]),
        .pu_en(port_a_pullup_en[gi]),
        .read_bit(pa_read[gi]),
        .func_in(pa_func[gi]),
        .adc_en(adc_in_en[gi])
      );
    end
  endgenerate

  gpt_pin_cell u_pb_cell (
    .dir(port_b_direction_reg_q),
    .latch(port_b_latch_reg_q),
    .pu_sel(port_b_pullup_reg_q),
    .analog(1'b0),
    .blocked(1'b0),
    .alt_out(1'b0),
    .pin_in(port3_bidir_pin_in),
    .pin_out(port3_bidir_pin_out),
    .pin_oe(port3_bidir_pin_oe),
    .pu_en(port3_bidir_pin_pullup_en),
    .read_bit(pb_read),
    .func_in(pb_func),
    .adc_en()
  );

  // Alternate inputs see the live level of pins that are neither analog nor oscillator-owned
  assign timer_in = pa_func;
  assign ext_irq_input_zero = pa_func[1];
  assign ext_irq_input_one = pb_func;

  // ==========================================================
  // AXI4-Lite write path
  assign awready = ce & ~aw_hold_q & ~bvalid_q;
  assign wready = ce & ~w_hold_q & ~bvalid_q;
  assign wr_fire = ce & aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_lane0 = wr_fire & w_strb_q[0];
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // Address and data are held until both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Write decode
  always_comb begin
    if (aw_addr_q == OFF_PA_LATCH || aw_addr_q == OFF_PB_LATCH) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == OFF_PA_DIR || aw_addr_q == OFF_PB_DIR) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == OFF_PA_PULLUP || aw_addr_q == OFF_PB_PULLUP) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == OFF_PA_ANALOG || aw_addr_q == OFF_STATUS) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Port latches take every write with byte lane 0 strobed, whatever the direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_latch_reg_q <= PA_LATCH_RST;
      port_b_latch_reg_q <= PB_LATCH_RST;
    end else if (ce && wr_lane0) begin
      if (aw_addr_q == OFF_PA_LATCH) begin
        port_a_latch_reg_q <= w_data_q[PA_W-1:0];
      end else if (aw_addr_q == OFF_PB_LATCH) begin
        port_b_latch_reg_q <= w_data_q[PB_BIDIR_BIT];
      end
    end
  end

  // Direction registers, input mode out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_direction_reg_q <= PA_DIR_RST;
      port_b_direction_reg_q <= PB_DIR_RST;
    end else if (ce && wr_lane0) begin
      if (aw_addr_q == OFF_PA_DIR) begin
        port_a_direction_reg_q <= w_data_q[PA_W-1:0];
      end else if (aw_addr_q == OFF_PB_DIR) begin
        port_b_direction_reg_q <= w_data_q[PB_BIDIR_BIT];
      end
    end
  end

  // Pull-up and analog select registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_pullup_reg_q <= PA_PULLUP_RST;
      port_b_pullup_reg_q <= PB_PULLUP_RST;
      port_a_analog_select_reg_q <= PA_ANALOG_RST;
    end else if (ce && wr_lane0) begin
      if (aw_addr_q == OFF_PA_PULLUP) begin
        port_a_pullup_reg_q <= w_data_q[PA_W-1:0];
      end else if (aw_addr_q == OFF_PB_PULLUP) begin
        port_b_pullup_reg_q <= w_data_q[PB_BIDIR_BIT];
      end else if (aw_addr_q == OFF_PA_ANALOG) begin
        port_a_analog_select_reg_q <= w_data_q[PA_W-1:0];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  assign arready = ce & ~rvalid_q;
  assign ar_fire = arvalid & arready;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Read decode with live pin levels
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (araddr == OFF_PA_LATCH) begin
      rd_word[PA_W-1:0] = pa_read;
    end else if (araddr == OFF_PB_LATCH) begin
      rd_word[PB_BIDIR_BIT] = pb_read;
      rd_word[PB_RSTPIN_BIT] = rst_is_port & reset_shared_input_pin;
    end else if (araddr == OFF_PA_DIR) begin
      rd_word[PA_W-1:0] = port_a_direction_reg_q;
    end else if (araddr == OFF_PB_DIR) begin
      rd_word[PB_BIDIR_BIT] = port_b_direction_reg_q;
    end else if (araddr == OFF_PA_PULLUP) begin
      rd_word[PA_W-1:0] = port_a_pullup_reg_q;
    end else if (araddr == OFF_PB_PULLUP) begin
      rd_word[PB_BIDIR_BIT] = port_b_pullup_reg_q;
    end else if (araddr == OFF_PA_ANALOG) begin
      rd_word[PA_W-1:0] = port_a_analog_select_reg_q;
    end else if (araddr == OFF_STATUS) begin
      rd_word[ST_MODE_LSB +: 3] = clk_mode;
      rd_word[ST_RSTPORT_BIT] = rst_is_port;
      rd_word[ST_LOADED_BIT] = opt_loaded;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data is registered, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_latch_wr;
    wr_lane0 && aw_addr_q == OFF_PA_LATCH;
  endsequence

  sequence s_pa_read;
    ar_fire && araddr == OFF_PA_LATCH;
  endsequence

  latch_write_a: assert property (s_latch_wr |=> port_a_latch_reg_q == $past(w_data_q[3:0]))
    else $error("port A latch did not take written value");
  porta_read_a: assert property (s_pa_read |=> rvalid && rdata[3:0] == $past(pa_read))
    else $error("port A read does not match pin or latch");
  dir_reset_a: assert property ($rose(aresetn) |-> port_a_direction_reg_q == 4'hF)
    else $error("port A not in input mode after reset");
  pb_reset_a: assert property ($rose(aresetn) |-> port_b_direction_reg_q && !port3_bidir_pin_oe)
    else $error("port B pin not in input mode after reset");
  crystal_block_a: assert property (clk_mode == GPT_CLK_CRYSTAL |->
      port_a_oe[3:2] == 2'h0 && adc_in_en[3:2] == 2'h0)
    else $error("oscillator pins usable with crystal source");
  ext_clock_a: assert property (clk_mode == GPT_CLK_EXTERNAL |->
      !port_a_oe[3] && !adc_in_en[3] && (port_a_oe[2] == !port_a_direction_reg_q[2]
      || port_a_analog_select_reg_q[2]))
    else $error("external clock pin handling wrong");
  analog_off_a: assert property (port_a_analog_select_reg_q[0] |->
      !port_a_oe[0] && !port_a_pullup_en[0] && !pa_read[0])
    else $error("analog pin still has port function");
  out_enable_a: assert property (!port_a_direction_reg_q[1]
      && !port_a_analog_select_reg_q[1]
      |-> port_a_oe[1] && port_a_out[1] == (port_a_latch_reg_q[1] | timer_out[1]))
    else $error("output mode does not drive the pin");
  pullup_sel_a: assert property (port_a_pullup_reg_q[0] && port_a_direction_reg_q[0]
      && !port_a_analog_select_reg_q[0] |-> port_a_pullup_en[0])
    else $error("pull-up not applied to input pin");
  write_resp_a: assert property (wr_lane0 && aw_addr_q == OFF_PB_PULLUP |=> bvalid
      && port_b_pullup_reg_q == $past(w_data_q[PB_BIDIR_BIT]))
    else $error("write response missing");

endmodule

//--- verification/gpt_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// Board side of the pins: outside drivers, pull-ups, floating lines
module gpt_pin_model (
  // Clock
  input wire logic aclk,
  // Device pin controls, bit 4 is the port B pin
  input wire logic [4:0] dev_out,
  input wire logic [4:0] dev_oe,
  input wire logic [4:0] dev_pu,
  input wire logic [1:0] osc_pulldown,
  // Outside drivers
  input wire logic [4:0] ext_en,
  input wire logic [4:0] ext_val,
  input wire logic rst_en,
  input wire logic rst_val,
  // Resolved pin levels
  output logic [4:0] pin_lvl,
  output logic rst_pin
);
  logic flt_q = 1'h0;
  logic [4:0] pd;

  // Undriven lines show a pattern that changes every cycle
  always_ff @(posedge aclk) begin
    flt_q <= ~flt_q;
  end

  assign pd = {1'h0, osc_pulldown, 2'h0};

  // Resolve each line from every party that may drive it
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (dev_oe[i]) pin_lvl[i] = dev_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (dev_pu[i]) pin_lvl[i] = 1'h1;
      else if (pd[i]) pin_lvl[i] = 1'h0;
      else pin_lvl[i] = flt_q ^ i[0];
    end
  end

  // Board pull-up holds the reset-shared pin high when nobody drives it
  assign rst_pin = rst_en ? rst_val : 1'h1;
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  import gpt_pkg::*;
  // ==========================================================
  // Signals
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, hold_reset, irq0, irq1, hr_seen;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, rr, osc_pulldown, opt_clk_sel = 2'h0, tmr_out = 2'h0;
  logic ce = 1'h1;
  logic opt_rst_is_port = 1'h0, rst_en = 1'h0, rst_val = 1'h1, rst_pin;
  logic [3:0] pa_out, pa_oe, pa_pu, adc_en, tmr_in;
  logic pb_out, pb_oe, pb_pu;
  logic [4:0] ext_en = 5'h00, ext_val = 5'h00, pin_lvl;
  gpt_clk_e clk_mode;
  int failures = 0;
  int num_checks = 0;

  // Clock
  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // ==========================================================
  // Design and board
  gpt_ports dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .opt_clk_sel(opt_clk_sel),
    .opt_rst_is_port(opt_rst_is_port), .port_a_in(pin_lvl[3:0]), .port_a_out(pa_out),
    .port_a_oe(pa_oe), .port_a_pullup_en(pa_pu), .osc_pulldown(osc_pulldown),
    .port3_bidir_pin_in(pin_lvl[4]), .port3_bidir_pin_out(pb_out), .port3_bidir_pin_oe(pb_oe),
    .port3_bidir_pin_pullup_en(pb_pu), .reset_shared_input_pin(rst_pin), .adc_in_en(adc_en),
    .timer_in(tmr_in), .timer_out(tmr_out), .ext_irq_input_zero(irq0), .ext_irq_input_one(irq1),
    .clk_mode(clk_mode), .hold_reset(hold_reset));

  gpt_pin_model pins (.aclk(aclk), .dev_out({pb_out, pa_out}), .dev_oe({pb_oe, pa_oe}),
    .dev_pu({pb_pu, pa_pu}), .osc_pulldown(osc_pulldown), .ext_en(ext_en), .ext_val(ext_val),
    .rst_en(rst_en), .rst_val(rst_val), .pin_lvl(pin_lvl), .rst_pin(rst_pin));

  // ==========================================================
  // Verdict, comparison and bus tasks
  task automatic wrap_up();
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    failures++;
    $display("[ERR] %0t %s timed out", $time, what);
    wrap_up();
  endtask

  // Write one word, hold each channel until taken, check the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw, done;
    logic [1:0] r;
    done = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      if (bvalid) begin
        r = bresp;
        done = 1'h1;
      end
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    if (!done) hang("write");
    chk(r, er, "write response");
  endtask

  // Read one word into rv and rr
  task automatic rd(input logic [7:0] a);
    logic ta, done;
    done = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      if (rvalid) begin
        rv = rdata;
        rr = rresp;
        done = 1'h1;
      end
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end
    if (!done) hang("read");
  endtask

  // Reset for 13 cycles, look at the pins while it is held
  task automatic rst();
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    @(negedge aclk);
    chk(osc_pulldown, 32'h3, "oscillator pins pulled low");
    chk(pa_oe, 32'h0, "port A drives in reset");
    chk(pb_oe, 32'h0, "port B drives in reset");
    hr_seen = hold_reset;
    @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    rd(OFF_PA_DIR);
    chk(rv, 32'hF, "port A direction after reset");
    rd(OFF_PB_DIR);
    chk(rv, 32'h4, "port B direction after reset");
  endtask

  task automatic t_dir_latch();
    ext_en <= 5'h0F;
    ext_val <= 5'h05;
    wr(OFF_PA_LATCH, 32'hA);
    rd(OFF_PA_LATCH);
    chk(rv, 32'h5, "input read gives pins");
    wr(OFF_PA_DIR, 32'h6);
    chk(pa_oe, 32'h9, "per-bit output enable");
    chk(pa_out, 32'hA, "latch written while input");
    rd(OFF_PA_LATCH);
    chk(rv, 32'hC, "mixed direction read");
    ext_en <= 5'h00;
    wr(OFF_PA_DIR, 32'hF);
  endtask

  task automatic t_pullup();
    wr(OFF_PA_DIR, 32'hC);
    wr(OFF_PA_PULLUP, 32'hF);
    chk(pa_pu, 32'hC, "pull-up on input pins only");
    wr(OFF_PB_PULLUP, 32'h4);
    chk(pb_pu, 32'h1, "port B pull-up");
    chk(irq1, 32'h1, "port B interrupt input");
    wr(OFF_PB_DIR, 32'h0);
    chk(pb_oe, 32'h1, "port B output mode");
    chk(pb_pu, 32'h0, "port B pull-up off as output");
    rd(OFF_PB_LATCH);
    chk(rv, 32'h0, "port B latch read");
    chk(irq1, 32'h0, "port B interrupt follows pin");
    wr(OFF_PB_DIR, 32'h4);
    wr(OFF_PB_PULLUP, 32'h0);
    wr(OFF_PA_PULLUP, 32'h0);
  endtask

  task automatic t_analog();
    wr(OFF_PA_ANALOG, 32'h3);
    wr(OFF_PA_DIR, 32'h0);
    chk(adc_en, 32'h3, "analog routing");
    chk(pa_oe, 32'hC, "analog pins not driven");
    wr(OFF_PA_ANALOG, 32'h0);
    wr(OFF_PA_DIR, 32'hF);
    ext_en <= 5'h0F;
    ext_val <= 5'h02;
    rd(OFF_PA_LATCH);
    chk(irq0, 32'h1, "interrupt input from pin 1");
    chk(tmr_in, 32'h2, "timer inputs from pins");
    ext_en <= 5'h00;
  endtask

  task automatic t_bus_err();
    wr(8'h40, 32'hF, RESP_SLVERR);
    rd(8'h40);
    chk(rr, RESP_SLVERR, "unmapped read response");
  endtask

  task automatic t_clk_src();
    gpt_clk_e em[3] = '{GPT_CLK_INTERNAL, GPT_CLK_CRYSTAL, GPT_CLK_EXTERNAL};
    logic [3:0] ok[3] = '{4'hF, 4'h3, 4'h7};
    for (int i = 0; i < 3; i++) begin
      opt_clk_sel <= 2'(i);
      rst();
      wr(OFF_STATUS, 32'h0);
      chk(clk_mode, em[i], "clock source from option byte");
      wr(OFF_PA_DIR, 32'h0);
      chk(pa_oe, ok[i], "oscillator pins as port");
      wr(OFF_PA_DIR, 32'hF);
      wr(OFF_PA_ANALOG, 32'hF);
      chk(adc_en, ok[i], "oscillator pins as analog");
    end
  endtask

  task automatic t_rst_pin();
    opt_clk_sel <= 2'h0;
    rst_en <= 1'h1;
    rst_val <= 1'h0;
    rst();
    chk(hold_reset, 32'h1, "pin acts as reset");
    rst_val <= 1'h1;
    @(posedge aclk);
    chk(hold_reset, 32'h0, "reset pin released");
    opt_rst_is_port <= 1'h1;
    rst_val <= 1'h0;
    rst();
    chk(hr_seen, 32'h1, "low pin holds reset before load");
    chk(hold_reset, 32'h0, "port role ignores reset");
    rst_val <= 1'h1;
    ext_en <= 5'h10;
    ext_val <= 5'h10;
    rd(OFF_PB_LATCH);
    chk(rv, 32'h14, "reset-shared pin read as input");
    rd(OFF_STATUS);
    chk(rv, 32'h31, "status after option load");
  endtask

  // Timer drive on pin 1, then bus refusal while the enable is low
  task automatic t_alt_ce();
    wr(OFF_PA_DIR, 32'hC);
    tmr_out <= 2'h2;
    @(posedge aclk);
    chk(pa_out, 32'h2, "timer output on pin 1");
    chk(pa_oe, 32'h3, "timer pins driven");
    ce <= 1'h0;
    @(posedge aclk);
    chk({awready, wready, arready}, 32'h0, "bus taken with enable low");
    ce <= 1'h1;
    tmr_out <= 2'h0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst();
    t_defaults();
    t_dir_latch();
    t_pullup();
    t_analog();
    t_bus_err();
    t_clk_src();
    t_rst_pin();
    t_alt_ce();
    wrap_up();
  end
endmodule
